// *** src/osd_defines.svh ***
// Register indices, field positions, reset values and timing counts
`ifndef OSD_DEFINES_SVH
`define OSD_DEFINES_SVH

`define OSD_ADDR_W 5
`define OSD_DATA_W 8

`define OSD_IDX_PROTECT 5'h00
`define OSD_IDX_DETECT 5'h01
`define OSD_IDX_SYSCLK_A 5'h02
`define OSD_IDX_SYSCLK_B 5'h03
`define OSD_IDX_PLL 5'h04
`define OSD_IDX_PCLK_SEL 5'h05
`define OSD_IDX_PMODE_A 5'h06
`define OSD_IDX_PMODE_B 5'h07
`define OSD_IDX_PMODE_C 5'h08
`define OSD_IDX_TB2_SPEC 5'h09
`define OSD_IDX_INV_A 5'h0a
`define OSD_IDX_INV_B 5'h0b
`define OSD_IDX_PORT9_DIR 5'h0c
`define OSD_IDX_SER3 5'h0d
`define OSD_IDX_SER4 5'h0e
`define OSD_IDX_VDET_B 5'h0f
`define OSD_IDX_LV_IRQ 5'h10
`define OSD_IDX_LAST 5'h10

`define OSD_PRT_CLOCK 0
`define OSD_PRT_MODE 1
`define OSD_PRT_PORTSER 2
`define OSD_PRT_VOLT 3

`define OSD_DET_ENABLE 0
`define OSD_DET_SRC_SEL 1
`define OSD_DET_FLAG 2
`define OSD_DET_HALTED 3
`define OSD_DET_ACTION 7

`define OSD_SCA_WAIT_GATE 2
`define OSD_SCA_MAIN_DIS 5
`define OSD_SCA_SUB_SEL 7
`define OSD_SCB_PLL_SEL 1
`define OSD_PMC_CLK_LOCK 1

`define OSD_SCA_LOCK_MASK 8'ha4
`define OSD_SCB_LOCK_MASK 8'h03
`define OSD_PLL_LOCK_MASK 8'hff

`define OSD_RST_PROTECT 8'h00
`define OSD_RST_DETECT 8'h00
`define OSD_RST_GP 8'h00

`define OSD_CLK_PERIOD_NS 10
`define OSD_STOP_TIME_NS 1000
`define OSD_STOP_CYCLES ((`OSD_STOP_TIME_NS + `OSD_CLK_PERIOD_NS - 1) / `OSD_CLK_PERIOD_NS)

`endif

// *** src/osd_pkg.sv ***
// Types shared by the oscillation monitor and protect block
package osd_pkg;
  typedef enum logic [1:0] {
    OSD_RUN = 2'b01,
    OSD_HALT = 2'b10
  } osd_state_type;

  typedef enum logic [3:0] {
    OSD_SRC_MAIN = 4'b0001,
    OSD_SRC_PLL = 4'b0010,
    OSD_SRC_ONCHIP = 4'b0100,
    OSD_SRC_SUB = 4'b1000
  } osd_src_type;
endpackage

// *** src/osd_mon_if.sv ***
// Event link between the clock monitor and the control block
`timescale 1ns/100ps
`default_nettype none
interface osd_mon_if;
  logic stop_evt;
  logic reosc_evt;
  logic stopped;
  modport mon (output stop_evt, output reosc_evt, output stopped);
  modport ctl (input stop_evt, input reosc_evt, input stopped);
endinterface
`default_nettype wire

// *** src/osd_clk_mon.sv ***
// Main oscillator activity monitor: stop and restart events
`include "osd_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module osd_clk_mon #(
  parameter int STOP_CYCLES = `OSD_STOP_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic main_osc_input_i,
  osd_mon_if.mon mon
);
  localparam int CW = $clog2(STOP_CYCLES + 1);

  generate
    if (STOP_CYCLES < 2) begin : g_chk
      $error("osd_clk_mon: STOP_CYCLES must be at least 2");
    end
  endgenerate

  logic sync_a;
  logic sync_b;
  logic last;
  logic [CW-1:0] idle_cnt;
  logic stopped;
  logic stop_evt;
  logic reosc_evt;
  logic edge_seen;

  // Pin crosses into sys_clk before anything looks at it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_a <= main_osc_input_i;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  assign edge_seen = sync_b ^ last;

  // R3: window assumes a fast crystal
  // Silence longer than the window means a stopped crystal
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= '0;
      stopped <= 1'b0;
      stop_evt <= 1'b0;
      reosc_evt <= 1'b0;
    end else begin
      stop_evt <= 1'b0;
      reosc_evt <= 1'b0;
      if (edge_seen) begin
        idle_cnt <= '0;
        if (stopped) begin
          stopped <= 1'b0;
          reosc_evt <= 1'b1;
        end
      end else if (!stopped) begin
        if (idle_cnt == CW'(STOP_CYCLES - 1)) begin
          stopped <= 1'b1;
          stop_evt <= 1'b1;
          idle_cnt <= '0;
        end else begin
          idle_cnt <= idle_cnt + CW'(1);
        end
      end
    end
  end

  assign mon.stop_evt = stop_evt;
  assign mon.reosc_evt = reosc_evt;
  assign mon.stopped = stopped;
endmodule
`default_nettype wire

// *** src/osd_wp_top.sv ***
// Oscillation stop detection and register write protection
//
// Functional notes
// R1: On a clock event, action select 0 forces reset, 1 raises interrupt.
// R2: Detection works only while the detection enable bit is 1.
// R3: Detection valid at 2 MHz and above; below, software keeps enable cleared.
// R4: Enable with action 0 and a stop initializes and halts the device.
// R5: Halted state leaves only through hardware reset.
// R6: Software avoids arming reset mode while the main clock is stopped.
// R7: Stop on main clock source: request, on-chip oscillator, switch, flags set.
// R8: Stop on PLL source: request and flags set, source select unchanged.
// R9: With PLL source, handler sets source select itself.
// R10: Restart: request, detect flag set, halted flag cleared, source unchanged.
// R11: Shared vector; software reads detect flag to find the requester.
// R12: Detect flag set with request; blocks further requests until written 0.
// R13: Stop in low-speed mode: CPU stays on sub clock, peripherals move on-chip.
// R14: Software switches back to the main clock after restart.
// R15: Software clears the wait peripheral gate before wait with detection.
// R16: Software clears enable before deliberately stopping or starting main clock.
// R17: Clock unlock bit gates writes to clock, PLL and peripheral clock registers.
// R18: Mode unlock bit gates processor mode, timer B2 and inverter registers.
// R19: Port and serial unlock bit gates port 9 direction and serial controls.
// R20: Voltage unlock bit gates voltage detect and low-voltage interrupt registers.
// R21: Port and serial unlock clears on next write; others only by software.
// R22: Software writes port and serial registers right after unlocking.
// R23: Clock change lock blocks writes to enable and clock selection bits.
// R24: Reset leaves all unlock bits cleared and detection disabled.
`include "osd_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module osd_wp_top #(
  parameter int STOP_CYCLES = `OSD_STOP_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic main_osc_input_i,
  input wire logic [`OSD_ADDR_W-1:0] addr_i,
  input wire logic [`OSD_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`OSD_DATA_W-1:0] rdata_o,
  output logic osc_irq_o,
  output logic osc_stop_reset_o,
  output logic onchip_osc_en_o,
  output logic [3:0] cpu_clk_src_o,
  output logic periph_clk_onchip_o,
  output logic main_clock_disable_o,
  output logic wait_peripheral_clock_gate_o
);
  localparam int NGP = 15;
  localparam int DW = `OSD_DATA_W;

  osd_mon_if mon_if ();

  osd_clk_mon #(
    .STOP_CYCLES(STOP_CYCLES)
  ) u_mon (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .main_osc_input_i(main_osc_input_i),
    .mon(mon_if)
  );

  osd_pkg::osd_state_type state;
  logic [DW-1:0] write_protect_reg;
  logic [DW-1:0] osc_detect_control_reg;
  logic [DW-1:0] gp [NGP];

  // Unlock bit guarding a register index; -1 for unguarded
  function automatic int prot_group(input logic [`OSD_ADDR_W-1:0] idx);
    case (idx)
      `OSD_IDX_DETECT, `OSD_IDX_SYSCLK_A, `OSD_IDX_SYSCLK_B,
      `OSD_IDX_PLL, `OSD_IDX_PCLK_SEL: prot_group = `OSD_PRT_CLOCK;
      `OSD_IDX_PMODE_A, `OSD_IDX_PMODE_B, `OSD_IDX_PMODE_C,
      `OSD_IDX_TB2_SPEC, `OSD_IDX_INV_A, `OSD_IDX_INV_B: prot_group = `OSD_PRT_MODE;
      `OSD_IDX_PORT9_DIR, `OSD_IDX_SER3, `OSD_IDX_SER4: prot_group = `OSD_PRT_PORTSER;
      `OSD_IDX_VDET_B, `OSD_IDX_LV_IRQ: prot_group = `OSD_PRT_VOLT;
      default: prot_group = -1;
    endcase
  endfunction

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [DW-1:0] keep);
    merge = (old_v & keep) | (new_v & ~keep);
  endfunction

  logic halted_now;
  logic wr_ok;
  logic clk_lock;
  logic det_en;
  logic act_irq;
  logic flag;
  logic sub_mode;
  logic pll_mode;
  logic src_sel;
  logic stop_hit;
  logic reosc_hit;
  int grp;

  assign halted_now = (state == osd_pkg::OSD_HALT);
  assign clk_lock = gp[`OSD_IDX_PMODE_C - 2][`OSD_PMC_CLK_LOCK];
  assign det_en = osc_detect_control_reg[`OSD_DET_ENABLE];
  assign act_irq = osc_detect_control_reg[`OSD_DET_ACTION];
  assign flag = osc_detect_control_reg[`OSD_DET_FLAG];
  assign src_sel = osc_detect_control_reg[`OSD_DET_SRC_SEL];
  assign sub_mode = gp[`OSD_IDX_SYSCLK_A - 2][`OSD_SCA_SUB_SEL];
  assign pll_mode = gp[`OSD_IDX_SYSCLK_B - 2][`OSD_SCB_PLL_SEL];

  // R2: events count only while enabled
  assign stop_hit = det_en && mon_if.stop_evt;
  assign reosc_hit = det_en && mon_if.reosc_evt;

  // R17: R18: R19: R20: unlock bit per register group
  always_comb begin
    grp = prot_group(addr_i);
    if (grp < 0) begin
      wr_ok = wr_i && !halted_now;
    end else begin
      wr_ok = wr_i && !halted_now && write_protect_reg[grp[1:0]];
    end
  end

  // R1: R4: R5: reset mode halts until hardware reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= osd_pkg::OSD_RUN;
    end else begin
      case (state)
        osd_pkg::OSD_RUN: begin
          if ((stop_hit || reosc_hit) && !act_irq) begin
            state <= osd_pkg::OSD_HALT;
          end
        end
        osd_pkg::OSD_HALT: state <= osd_pkg::OSD_HALT;
        default: state <= osd_pkg::OSD_RUN;
      endcase
    end
  end

  // R24: reset leaves every group locked
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_protect_reg <= `OSD_RST_PROTECT;
    end else if (halted_now) begin
      write_protect_reg <= `OSD_RST_PROTECT;
    end else if (wr_i && addr_i == `OSD_IDX_PROTECT) begin
      write_protect_reg <= {4'h0, wdata_i[3:0]};
    end else if (wr_i) begin
      // R21: port and serial unlock spent by the next write
      write_protect_reg[`OSD_PRT_PORTSER] <= 1'b0;
    end
  end

  // Protected general storage, re-initialized while halted
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NGP; i++) begin
        gp[i] <= `OSD_RST_GP;
      end
    end else if (halted_now) begin
      for (int i = 0; i < NGP; i++) begin
        gp[i] <= `OSD_RST_GP;
      end
    end else if (wr_ok && addr_i >= `OSD_IDX_SYSCLK_A && addr_i <= `OSD_IDX_LAST) begin
      case (addr_i)
        // R23: clock change lock freezes selection bits
        `OSD_IDX_SYSCLK_A: begin
          gp[addr_i - 2] <= merge(gp[addr_i - 2], wdata_i,
                                  clk_lock ? `OSD_SCA_LOCK_MASK : 8'h00);
        end
        `OSD_IDX_SYSCLK_B: begin
          gp[addr_i - 2] <= merge(gp[addr_i - 2], wdata_i,
                                  clk_lock ? `OSD_SCB_LOCK_MASK : 8'h00);
        end
        `OSD_IDX_PLL: begin
          gp[addr_i - 2] <= merge(gp[addr_i - 2], wdata_i,
                                  clk_lock ? `OSD_PLL_LOCK_MASK : 8'h00);
        end
        default: gp[addr_i - 2] <= wdata_i;
      endcase
    end
  end

  // Detection control and status; hardware set wins over software clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_detect_control_reg <= `OSD_RST_DETECT;
    end else if (halted_now) begin
      osc_detect_control_reg <= `OSD_RST_DETECT;
    end else begin
      if (wr_ok && addr_i == `OSD_IDX_DETECT) begin
        // R23: enable frozen under clock change lock
        if (!clk_lock) begin
          osc_detect_control_reg[`OSD_DET_ENABLE] <= wdata_i[`OSD_DET_ENABLE];
        end
        osc_detect_control_reg[`OSD_DET_SRC_SEL] <= wdata_i[`OSD_DET_SRC_SEL];
        osc_detect_control_reg[`OSD_DET_ACTION] <= wdata_i[`OSD_DET_ACTION];
        // R12: writing 0 re-arms the request
        if (!wdata_i[`OSD_DET_FLAG]) begin
          osc_detect_control_reg[`OSD_DET_FLAG] <= 1'b0;
        end
      end
      if (act_irq && stop_hit) begin
        // R7: R8: flags set on stop
        osc_detect_control_reg[`OSD_DET_FLAG] <= 1'b1;
        osc_detect_control_reg[`OSD_DET_HALTED] <= 1'b1;
        // R7: R8: R13: only a main-clock CPU switches source
        if (!pll_mode && !sub_mode) begin
          osc_detect_control_reg[`OSD_DET_SRC_SEL] <= 1'b1;
        end
      end
      if (act_irq && reosc_hit) begin
        // R10: restart clears halted, keeps source
        osc_detect_control_reg[`OSD_DET_FLAG] <= 1'b1;
        osc_detect_control_reg[`OSD_DET_HALTED] <= 1'b0;
      end
    end
  end

  // R12: one request per armed flag
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_irq_o <= 1'b0;
    end else begin
      osc_irq_o <= act_irq && !flag && !halted_now && (stop_hit || reosc_hit);
    end
  end

  // R4: halt indication held until hardware reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_stop_reset_o <= 1'b0;
    end else begin
      osc_stop_reset_o <= halted_now || ((stop_hit || reosc_hit) && !act_irq);
    end
  end

  // Clock routing follows register state one cycle later
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_clk_src_o <= osd_pkg::OSD_SRC_MAIN;
      onchip_osc_en_o <= 1'b0;
      periph_clk_onchip_o <= 1'b0;
      main_clock_disable_o <= 1'b0;
      wait_peripheral_clock_gate_o <= 1'b0;
    end else begin
      // R13: sub clock keeps the CPU
      if (sub_mode) begin
        cpu_clk_src_o <= osd_pkg::OSD_SRC_SUB;
      end else if (src_sel) begin
        cpu_clk_src_o <= osd_pkg::OSD_SRC_ONCHIP;
      end else if (pll_mode) begin
        cpu_clk_src_o <= osd_pkg::OSD_SRC_PLL;
      end else begin
        cpu_clk_src_o <= osd_pkg::OSD_SRC_MAIN;
      end
      // R7: R13: on-chip oscillator runs while needed
      onchip_osc_en_o <= src_sel || osc_detect_control_reg[`OSD_DET_HALTED];
      periph_clk_onchip_o <= src_sel || (sub_mode && osc_detect_control_reg[`OSD_DET_HALTED]);
      main_clock_disable_o <= gp[`OSD_IDX_SYSCLK_A - 2][`OSD_SCA_MAIN_DIS];
      wait_peripheral_clock_gate_o <= gp[`OSD_IDX_SYSCLK_A - 2][`OSD_SCA_WAIT_GATE];
    end
  end

  // Read data stands the cycle after the strobe; unmapped reads 0
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i == `OSD_IDX_PROTECT) begin
        rdata_o <= write_protect_reg;
      end else if (addr_i == `OSD_IDX_DETECT) begin
        // R11: flag visible for source identification
        rdata_o <= osc_detect_control_reg;
      end else if (addr_i <= `OSD_IDX_LAST) begin
        rdata_o <= gp[addr_i - 2];
      end else begin
        rdata_o <= '0;
      end
    end else begin
      rdata_o <= '0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/osd_osc_model.sv ***
// Main crystal oscillator stand-in that can be stopped and restarted
`timescale 1ns/100ps
`default_nettype none
module osd_osc_model (
  input wire logic sys_clk_i,
  input wire logic run_i,
  output logic osc_o
);
  initial osc_o = 1'b0;
  // rate far above minimum
  // A stopped crystal just sits at its last level
  always @(posedge sys_clk_i) begin
    if (run_i) begin
      osc_o <= ~osc_o;
    end
  end
endmodule
`default_nettype wire

// *** testbench/osd_wp_top_chk.sv ***
// Port-level checker for the oscillation monitor and protect block
`timescale 1ns/100ps
`default_nettype none
module osd_wp_top_chk #(
  parameter int STOP_CYCLES = 100
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic osc_irq_o,
  input wire logic osc_stop_reset_o,
  input wire logic onchip_osc_en_o,
  input wire logic [3:0] cpu_clk_src_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_irq_pulse;
    osc_irq_o |=> !osc_irq_o [*2];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq not a single pulse");
  property p_halt_hold;
    osc_stop_reset_o |=> osc_stop_reset_o;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("stop reset released without reset");
  property p_halt_no_irq;
    osc_stop_reset_o |-> !osc_irq_o;
  endproperty
  a_halt_no_irq: assert property (p_halt_no_irq)
    else $error("irq in reset action");
  property p_halt_frozen;
    osc_stop_reset_o [*3] |=> $stable(cpu_clk_src_o);
  endproperty
  a_halt_frozen: assert property (p_halt_frozen)
    else $error("clock source moved while halted");
  property p_halt_init;
    osc_stop_reset_o [*3] |-> cpu_clk_src_o == osd_pkg::OSD_SRC_MAIN;
  endproperty
  a_halt_init: assert property (p_halt_init)
    else $error("halt did not reinitialise source");
  property p_src_onehot;
    $onehot(cpu_clk_src_o);
  endproperty
  a_src_onehot: assert property (p_src_onehot)
    else $error("cpu source not one-hot");
  property p_onchip_run;
    cpu_clk_src_o == osd_pkg::OSD_SRC_ONCHIP |-> onchip_osc_en_o;
  endproperty
  a_onchip_run: assert property (p_onchip_run)
    else $error("on-chip source without oscillator");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule
bind osd_wp_top osd_wp_top_chk #(.STOP_CYCLES(STOP_CYCLES)) i_osd_wp_top_chk (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .osc_irq_o(osc_irq_o),
  .osc_stop_reset_o(osc_stop_reset_o),
  .onchip_osc_en_o(onchip_osc_en_o),
  .cpu_clk_src_o(cpu_clk_src_o)
);
`default_nettype wire

// *** testbench/test_osd_wp_top.sv ***
// Self-checking bench for the oscillation monitor and protect block
`timescale 1ns/100ps
`default_nettype none
`include "osd_defines.svh"
module test_osd_wp_top;
  localparam logic [4:0] a_prot = `OSD_IDX_PROTECT;
  localparam logic [4:0] a_det = `OSD_IDX_DETECT;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic run = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic osc, irq, srst, oen, pon, mdis, wgate;
  logic [3:0] src;
  logic [4:0] grp [4];
  int num_errors = 0;
  int n_compared = 0;
  int nirq = 0;
  int i;
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (irq === 1'b1) begin
      nirq <= nirq + 1;
    end
  end
  osd_osc_model i_osd_osc_model (.sys_clk_i(sys_clk_i), .run_i(run), .osc_o(osc));
  // Short stop count keeps each stop detection to about a dozen cycles
  osd_wp_top #(.STOP_CYCLES(8)) i_osd_wp_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .main_osc_input_i(osc), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdat), .osc_irq_o(irq), .osc_stop_reset_o(srst), .onchip_osc_en_o(oen),
    .cpu_clk_src_o(src), .periph_clk_onchip_o(pon), .main_clock_disable_o(mdis),
    .wait_peripheral_clock_gate_o(wgate));
  task automatic chk(input string s, input logic [7:0] v, input logic [7:0] e);
    n_compared++;
    if (v !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdat, e);
  endtask
  task automatic osc_set(input logic b, input int n);
    int n0;
    n0 = nirq;
    @(posedge sys_clk_i);
    run <= b;
    repeat (40) @(posedge sys_clk_i);
    chk("irq count", 8'(nirq - n0), 8'(n));
  endtask
  task automatic out_chk(input osd_pkg::osd_src_type e, input logic on);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("cpu src", {4'h0, src}, {4'h0, e});
    chk("onchip", {7'h00, oen}, {7'h00, on});
  endtask
  task automatic rst;
    nrst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
  endtask
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    num_errors++;
    end_sim();
  end
  initial begin
    grp = '{`OSD_IDX_PLL, `OSD_IDX_TB2_SPEC, `OSD_IDX_PORT9_DIR, `OSD_IDX_VDET_B};
    rst();
    rd_chk(a_prot, 8'h00);
    rd_chk(a_det, 8'h00);
    out_chk(osd_pkg::OSD_SRC_MAIN, 1'b0);
    osc_set(1'b0, 0);
    rd_chk(a_det, 8'h00);
    osc_set(1'b1, 0);
    for (i = 0; i < 4; i++) begin
      wr_reg(grp[i], 8'h5a);
      rd_chk(grp[i], 8'h00);
      wr_reg(a_prot, 8'h01 << i);
      wr_reg(grp[i], 8'h5a);
      rd_chk(grp[i], 8'h5a);
    end
    rd_chk(a_prot, 8'h08);
    // Unmapped write still spends the one-shot unlock
    wr_reg(a_prot, 8'h05);
    wr_reg(5'h1f, 8'h33);
    wr_reg(`OSD_IDX_PORT9_DIR, 8'h33);
    rd_chk(`OSD_IDX_PORT9_DIR, 8'h5a);
    rd_chk(a_prot, 8'h01);
    wr_reg(`OSD_IDX_SYSCLK_A, 8'h24);
    @(posedge sys_clk_i);
    #1;
    chk("sysclk a", {6'h00, mdis, wgate}, 8'h03);
    wr_reg(`OSD_IDX_SYSCLK_A, 8'h00);
    wr_reg(a_prot, 8'h03);
    wr_reg(`OSD_IDX_PMODE_C, 8'h02);
    wr_reg(a_det, 8'h01);
    wr_reg(`OSD_IDX_PLL, 8'h00);
    rd_chk(a_det, 8'h00);
    rd_chk(`OSD_IDX_PLL, 8'h5a);
    wr_reg(`OSD_IDX_PMODE_C, 8'h00);
    wr_reg(a_det, 8'h81);
    osc_set(1'b0, 1);
    rd_chk(a_det, 8'h8f);
    out_chk(osd_pkg::OSD_SRC_ONCHIP, 1'b1);
    chk("periph", {7'h00, pon}, 8'h01);
    osc_set(1'b1, 0);
    rd_chk(a_det, 8'h87);
    wr_reg(a_det, 8'h83);
    osc_set(1'b0, 1);
    wr_reg(a_det, 8'h83);
    osc_set(1'b1, 1);
    rd_chk(a_det, 8'h87);
    out_chk(osd_pkg::OSD_SRC_ONCHIP, 1'b1);
    wr_reg(a_det, 8'h81);
    wr_reg(`OSD_IDX_SYSCLK_B, 8'h02);
    out_chk(osd_pkg::OSD_SRC_PLL, 1'b0);
    osc_set(1'b0, 1);
    rd_chk(a_det, 8'h8d);
    out_chk(osd_pkg::OSD_SRC_PLL, 1'b1);
    wr_reg(a_det, 8'h83);
    out_chk(osd_pkg::OSD_SRC_ONCHIP, 1'b1);
    osc_set(1'b1, 1);
    wr_reg(`OSD_IDX_SYSCLK_B, 8'h00);
    wr_reg(a_det, 8'h81);
    wr_reg(`OSD_IDX_SYSCLK_A, 8'h80);
    out_chk(osd_pkg::OSD_SRC_SUB, 1'b0);
    osc_set(1'b0, 1);
    out_chk(osd_pkg::OSD_SRC_SUB, 1'b1);
    chk("periph", {7'h00, pon}, 8'h01);
    rst();
    osc_set(1'b1, 0);
    wr_reg(a_prot, 8'h01);
    wr_reg(a_det, 8'h01);
    osc_set(1'b0, 0);
    chk("stop reset", {7'h00, srst}, 8'h01);
    wr_reg(a_prot, 8'h01);
    rd_chk(a_prot, 8'h00);
    repeat (20) @(posedge sys_clk_i);
    chk("stop reset", {7'h00, srst}, 8'h01);
    rst();
    #1;
    chk("stop reset", {7'h00, srst}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
